// *** mcis_core_model.sv ***
// Behavioural core: instruction boundaries, interrupt returns and sleep.
// Assumes one clock per machine cycle; the bench sets instruction length and returns.
`timescale 1ns/1ps
`default_nettype none
module mcis_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Bench controls
    input wire logic [4:0] ilen,
    input wire logic do_interrupt_return_instruction,
    input wire logic sleep,
    // Sequencer side
    input wire logic call_busy,
    output logic core_last_cycle,
    output logic core_is_interrupt_return_instruction,
    output logic core_interrupt_return_instruction_done,
    output logic core_sleeping
);
    logic [4:0] cnt_reg;
    // No instruction ends while the call or sleep holds the core.
    assign core_last_cycle = cnt_reg == ilen - 5'h1 && !call_busy && !sleep;
    assign core_sleeping = sleep;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 5'h0;
            core_is_interrupt_return_instruction <= 1'b0;
            core_interrupt_return_instruction_done <= 1'b0;
        end else begin
            core_interrupt_return_instruction_done <= core_last_cycle && core_is_interrupt_return_instruction;
            if (core_last_cycle) begin
                cnt_reg <= 5'h0;
                core_is_interrupt_return_instruction <= do_interrupt_return_instruction && !core_is_interrupt_return_instruction;
            end else if (!call_busy && !sleep) begin
                cnt_reg <= cnt_reg + 5'h1;
            end
        end
    end
endmodule : mcis_core_model
`default_nettype wire

// *** mcis_ext_trig.sv ***
// One external interrupt pin: synchroniser, previous-sample register and trigger decode.
// Assumes the pin is asynchronous to ref_clk; one clock is one machine cycle.
`timescale 1ns/1ps
`default_nettype none
module mcis_ext_trig (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Pin and mode
    input wire logic pin,
    input wire mcis_pkg::mcis_trig_t mode,
    // Decoded request
    output logic set_req,
    output logic is_level
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic fall;
    logic rise;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'h1;
            sync2_reg <= 1'h1;
            prev_reg <= 1'h1;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign fall = prev_reg & ~sync2_reg;
    assign rise = ~prev_reg & sync2_reg;
    assign is_level = (mode == mcis_pkg::TRIG_LOW);

    always_comb begin
        case (mode)
            mcis_pkg::TRIG_LOW: set_req = ~sync2_reg;
            mcis_pkg::TRIG_FALL: set_req = fall;
            mcis_pkg::TRIG_RISE: set_req = rise;
            default: set_req = fall | rise;
        endcase
    end
endmodule : mcis_ext_trig
`default_nettype wire

// *** mcis_pkg.sv ***
// Types shared by the interrupt sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package mcis_pkg;
    typedef enum logic [1:0] {
        TRIG_LOW = 2'h0,
        TRIG_FALL = 2'h1,
        TRIG_RISE = 2'h2,
        TRIG_BOTH = 2'h3
    } mcis_trig_t;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_CALL = 3'h2,
        SEQ_HOLD = 3'h4
    } mcis_seq_t;
endpackage : mcis_pkg

// *** mcis_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the interrupt sequencer.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef MCIS_REGS_SVH
`define MCIS_REGS_SVH
`define MCIS_ADDR_EN_LO 4'h0
`define MCIS_ADDR_EN_HI 4'h1
`define MCIS_ADDR_PIN4_EN 4'h2
`define MCIS_ADDR_TRIG 4'h3
`define MCIS_ADDR_EXT_FLAG 4'h4
`define MCIS_ADDR_PRI_LO0 4'h5
`define MCIS_ADDR_PRI_LO1 4'h6
`define MCIS_ADDR_PRI_HI0 4'h7
`define MCIS_ADDR_PRI_HI1 4'h8
`define MCIS_ADDR_STATUS 4'h9
`define MCIS_RST_BYTE 8'h00
`define MCIS_EN_HI_CM 3
`define MCIS_EN_HI_CM_AUX 4
`define MCIS_EN_HI_LV 5
`define MCIS_SRC_EXT2 4'h4
`define MCIS_SRC_EXT3 4'h5
`define MCIS_MCYCLE_NS 10
`define MCIS_CALL_CYCLES 3'h7
`define MCIS_INTERRUPT_RETURN_INSTRUCTION_WAIT 4'h8
`define MCIS_VEC_T5 16'h000b
`define MCIS_VEC_SERIAL 16'h0023
`define MCIS_VEC_T2 16'h002b
`define MCIS_VEC_ADC 16'h0033
`define MCIS_VEC_EXT2 16'h0043
`define MCIS_VEC_EXT3 16'h004b
`define MCIS_VEC_EXT4 16'h0053
`define MCIS_VEC_T3 16'h005b
`define MCIS_VEC_PWM 16'h0063
`define MCIS_VEC_T4 16'h006b
`define MCIS_VEC_CM_LV 16'h0073
`endif

// *** mcis_sequencer.sv ***
// Interrupt sequencer: request gating, priority poll, vector call and in-progress tracking.
// Assumes the core reports instruction boundaries on ref_clk; one clock is one machine cycle.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mcis_regs.svh"
module mcis_sequencer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Peripheral request flags
    input wire logic timer_five_overflow_flag,
    input wire logic serial_receive_flag,
    input wire logic serial_transmit_flag,
    input wire logic timer_two_overflow_flag,
    input wire logic converter_done_flag,
    input wire logic timer_three_overflow_flag,
    input wire logic pulse_width_flag,
    input wire logic timer_four_overflow_flag,
    input wire logic clock_monitor_flag,
    input wire logic low_voltage_detect_flag,
    // External interrupt pins
    input wire logic ext_irq_two_pin,
    input wire logic ext_irq_three_pin,
    input wire logic [3:0] ext_irq_four_group,
    // Core instruction status
    input wire logic core_last_cycle,
    input wire logic core_is_interrupt_return_instruction,
    input wire logic core_interrupt_return_instruction_done,
    input wire logic core_sleeping,
    // Vector call to the core
    output logic hardware_vector_call,
    output logic [15:0] vector_addr,
    output logic [1:0] vector_level,
    output logic call_busy,
    output logic wake_req
);
    logic [7:0] en_lo_reg;
    logic [5:0] en_hi_reg;
    logic [3:0] pin4_en_reg;
    logic [5:0] trig_reg;
    logic [10:0] pri_lo_reg;
    logic [10:0] pri_hi_reg;
    logic [5:0] ext_flag;
    logic [5:0] ext_set;
    logic [5:0] ext_lvl;
    logic [5:0] ext_pins;
    logic [10:0] req_m;
    logic [10:0] req_s_reg;
    logic poll_hit;
    logic [3:0] poll_src;
    logic [1:0] poll_lvl;
    logic poll_valid_reg;
    logic [3:0] poll_src_reg;
    logic [1:0] poll_lvl_reg;
    logic [3:0] in_prog_reg;
    logic act_any;
    logic [1:0] act_top;
    logic issue;
    mcis_pkg::mcis_seq_t seq_reg;
    logic [2:0] call_cnt_reg;
    logic [3:0] hold_cnt_reg;
    logic hold_instr_reg;
    logic [3:0] vec_src_reg;
    logic [7:0] rdata_reg;
    // Channel four needs both the group enable and its pin enable.
    assign req_m = {
        (clock_monitor_flag & en_hi_reg[`MCIS_EN_HI_CM] & en_hi_reg[`MCIS_EN_HI_CM_AUX])
            | (low_voltage_detect_flag & en_hi_reg[`MCIS_EN_HI_LV]),
        timer_four_overflow_flag & en_hi_reg[2],
        pulse_width_flag & en_hi_reg[1],
        timer_three_overflow_flag & en_hi_reg[0],
        en_lo_reg[6] & (|(ext_flag[5:2] & pin4_en_reg)),
        ext_flag[1] & en_lo_reg[5],
        ext_flag[0] & en_lo_reg[4],
        converter_done_flag & en_lo_reg[3],
        timer_two_overflow_flag & en_lo_reg[2],
        (serial_receive_flag | serial_transmit_flag) & en_lo_reg[1],
        timer_five_overflow_flag & en_lo_reg[0]
    };
    // Stage one samples the gated requests on every rising edge.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            req_s_reg <= '0;
        end else begin
            req_s_reg <= req_m;
        end
    end
    // Later loop passes override earlier ones: highest level, then lowest index.
    always_comb begin
        poll_hit = 1'h0;
        poll_src = 4'h0;
        poll_lvl = 2'h0;
        for (int l = 0; l < 4; l++) begin
            for (int s = 10; s >= 0; s--) begin
                if (req_s_reg[s] && ({pri_hi_reg[s], pri_lo_reg[s]} == 2'(l))) begin
                    poll_hit = 1'h1;
                    poll_src = 4'(s);
                    poll_lvl = 2'(l);
                end
            end
        end
    end
    // Stage two holds the poll result; the call is raised a cycle later.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            poll_valid_reg <= 1'h0;
            poll_src_reg <= 4'h0;
            poll_lvl_reg <= 2'h0;
        end else begin
            poll_valid_reg <= poll_hit;
            poll_src_reg <= poll_src;
            poll_lvl_reg <= poll_lvl;
        end
    end
    always_comb begin
        act_top = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (in_prog_reg[l]) begin
                act_top = 2'(l);
            end
        end
    end
    assign act_any = |in_prog_reg;
    // The polled source is re-checked so a request that dropped meanwhile is not taken.
    assign issue = (seq_reg == mcis_pkg::SEQ_IDLE) && poll_valid_reg
        && req_s_reg[poll_src_reg]
        && (!act_any || (poll_lvl_reg > act_top))
        && core_last_cycle
        && !core_is_interrupt_return_instruction && !core_interrupt_return_instruction_done;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            seq_reg <= mcis_pkg::SEQ_IDLE;
            call_cnt_reg <= 3'h0;
            hold_cnt_reg <= 4'h0;
            hold_instr_reg <= 1'h0;
        end else begin
            case (seq_reg)
                mcis_pkg::SEQ_IDLE: begin
                    if (core_interrupt_return_instruction_done) begin
                        seq_reg <= mcis_pkg::SEQ_HOLD;
                        hold_cnt_reg <= `MCIS_INTERRUPT_RETURN_INSTRUCTION_WAIT;
                        hold_instr_reg <= 1'h0;
                    end else if (issue) begin
                        seq_reg <= mcis_pkg::SEQ_CALL;
                        call_cnt_reg <= `MCIS_CALL_CYCLES - 3'h1;
                    end
                end
                mcis_pkg::SEQ_CALL: begin
                    if (call_cnt_reg == 3'h0) begin
                        seq_reg <= mcis_pkg::SEQ_IDLE;
                    end else begin
                        call_cnt_reg <= call_cnt_reg - 3'h1;
                    end
                end
                mcis_pkg::SEQ_HOLD: begin
                    if (hold_cnt_reg != 4'h0) begin
                        hold_cnt_reg <= hold_cnt_reg - 4'h1;
                    end
                    if (core_last_cycle && !core_is_interrupt_return_instruction) begin
                        hold_instr_reg <= 1'h1;
                    end
                    if (core_interrupt_return_instruction_done) begin
                        hold_cnt_reg <= `MCIS_INTERRUPT_RETURN_INSTRUCTION_WAIT;
                        hold_instr_reg <= 1'h0;
                    end else if (hold_cnt_reg <= 4'h1 && hold_instr_reg) begin
                        seq_reg <= mcis_pkg::SEQ_IDLE;
                    end
                end
                default: seq_reg <= mcis_pkg::SEQ_IDLE;
            endcase
        end
    end
    // Only the interrupt return clears a level; a plain return is not reported at all.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_prog_reg <= 4'h0;
        end else begin
            for (int l = 0; l < 4; l++) begin
                if (issue && poll_lvl_reg == 2'(l)) begin
                    in_prog_reg[l] <= 1'h1;
                end else if (core_interrupt_return_instruction_done && act_top == 2'(l)) begin
                    in_prog_reg[l] <= 1'h0;
                end
            end
        end
    end
    // The core pushes only the program counter; the status word is left alone.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hardware_vector_call <= 1'h0;
            vector_addr <= 16'h0000;
            vector_level <= 2'h0;
            vec_src_reg <= 4'h0;
            call_busy <= 1'h0;
            wake_req <= 1'h0;
        end else begin
            hardware_vector_call <= issue;
            call_busy <= issue || (seq_reg == mcis_pkg::SEQ_CALL && call_cnt_reg != 3'h0);
            wake_req <= core_sleeping && (|req_m);
            if (issue) begin
                vec_src_reg <= poll_src_reg;
                vector_level <= poll_lvl_reg;
                case (poll_src_reg)
                    4'h0: vector_addr <= `MCIS_VEC_T5;
                    4'h1: vector_addr <= `MCIS_VEC_SERIAL;
                    4'h2: vector_addr <= `MCIS_VEC_T2;
                    4'h3: vector_addr <= `MCIS_VEC_ADC;
                    4'h4: vector_addr <= `MCIS_VEC_EXT2;
                    4'h5: vector_addr <= `MCIS_VEC_EXT3;
                    4'h6: vector_addr <= `MCIS_VEC_EXT4;
                    4'h7: vector_addr <= `MCIS_VEC_T3;
                    4'h8: vector_addr <= `MCIS_VEC_PWM;
                    4'h9: vector_addr <= `MCIS_VEC_T4;
                    default: vector_addr <= `MCIS_VEC_CM_LV;
                endcase
            end
        end
    end
    assign ext_pins = {ext_irq_four_group, ext_irq_three_pin, ext_irq_two_pin};
    // Pins 0 and 1 are channels two and three; pins 2 to 5 share channel four's mode.
    for (genvar i = 0; i < 6; i++) begin : g_ext
        logic flag_q;
        logic hw_clr;
        mcis_pkg::mcis_trig_t mode;
        assign mode = (i == 0) ? mcis_pkg::mcis_trig_t'(trig_reg[1:0])
            : (i == 1) ? mcis_pkg::mcis_trig_t'(trig_reg[3:2])
            : mcis_pkg::mcis_trig_t'(trig_reg[5:4]);
        mcis_ext_trig u_trig (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .pin(ext_pins[i]),
            .mode(mode),
            .set_req(ext_set[i]),
            .is_level(ext_lvl[i])
        );
        assign hw_clr = (i < 2) && issue && (poll_src_reg == 4'(4 + i));
        // A new trigger in the clearing cycle wins over either clear.
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                flag_q <= 1'h0;
            end else if ((i < 2) && ext_lvl[i]) begin
                flag_q <= ext_set[i];
            end else if (ext_set[i]) begin
                flag_q <= 1'h1;
            end else if (hw_clr) begin
                flag_q <= 1'h0;
            end else if (reg_wr && reg_addr == `MCIS_ADDR_EXT_FLAG) begin
                flag_q <= reg_wdata[i];
            end
        end
        assign ext_flag[i] = flag_q;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            en_lo_reg <= `MCIS_RST_BYTE;
            en_hi_reg <= 6'h00;
            pin4_en_reg <= 4'h0;
            trig_reg <= 6'h00;
            pri_lo_reg <= 11'h000;
            pri_hi_reg <= 11'h000;
        end else if (reg_wr) begin
            case (reg_addr)
                `MCIS_ADDR_EN_LO: en_lo_reg <= reg_wdata;
                `MCIS_ADDR_EN_HI: en_hi_reg <= reg_wdata[5:0];
                `MCIS_ADDR_PIN4_EN: pin4_en_reg <= reg_wdata[3:0];
                `MCIS_ADDR_TRIG: trig_reg <= reg_wdata[5:0];
                `MCIS_ADDR_PRI_LO0: pri_lo_reg[7:0] <= reg_wdata;
                `MCIS_ADDR_PRI_LO1: pri_lo_reg[10:8] <= reg_wdata[2:0];
                `MCIS_ADDR_PRI_HI0: pri_hi_reg[7:0] <= reg_wdata;
                `MCIS_ADDR_PRI_HI1: pri_hi_reg[10:8] <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= `MCIS_RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `MCIS_ADDR_EN_LO: rdata_reg <= en_lo_reg;
                `MCIS_ADDR_EN_HI: rdata_reg <= {2'h0, en_hi_reg};
                `MCIS_ADDR_PIN4_EN: rdata_reg <= {4'h0, pin4_en_reg};
                `MCIS_ADDR_TRIG: rdata_reg <= {2'h0, trig_reg};
                `MCIS_ADDR_EXT_FLAG: rdata_reg <= {2'h0, ext_flag};
                `MCIS_ADDR_PRI_LO0: rdata_reg <= pri_lo_reg[7:0];
                `MCIS_ADDR_PRI_LO1: rdata_reg <= {5'h00, pri_lo_reg[10:8]};
                `MCIS_ADDR_PRI_HI0: rdata_reg <= pri_hi_reg[7:0];
                `MCIS_ADDR_PRI_HI1: rdata_reg <= {5'h00, pri_hi_reg[10:8]};
                `MCIS_ADDR_STATUS: rdata_reg <= {vec_src_reg, in_prog_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign reg_rdata = rdata_reg;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_call_length: assert property ($rose(call_busy) |-> call_busy [*7] ##1 !call_busy)
        else $error("vector call did not occupy seven cycles");
    chk_call_boundary: assert property (hardware_vector_call
        |-> $past(core_last_cycle) && !$past(core_is_interrupt_return_instruction))
        else $error("vector call outside an instruction's final cycle");
    chk_call_level: assert property (hardware_vector_call
        |-> !$past(act_any) || (vector_level > $past(act_top)))
        else $error("vector call while equal or higher level in progress");
    chk_interrupt_return_instruction_wait: assert property (core_interrupt_return_instruction_done && seq_reg != mcis_pkg::SEQ_CALL
        |=> !hardware_vector_call [*8])
        else $error("vector call within eight cycles of interrupt return");
    chk_interrupt_return_instruction_clear: assert property (core_interrupt_return_instruction_done && act_any && !issue
        |=> in_prog_reg == ($past(in_prog_reg) & ~(4'h1 << $past(act_top))))
        else $error("interrupt return did not clear the current level");
    chk_poll_latency: assert property (hardware_vector_call
        |-> $past(poll_valid_reg) && $past(req_s_reg[poll_src_reg], 1))
        else $error("vector call without a polled request");
    chk_ext_autoclr: assert property (hardware_vector_call && vec_src_reg == `MCIS_SRC_EXT2
        && !ext_lvl[0] |-> !ext_flag[0] || $past(ext_set[0]))
        else $error("channel two flag not cleared on vectoring");
    chk_wake_req: assert property (core_sleeping && (|req_m) |=> wake_req)
        else $error("enabled request did not wake the core");
    chk_vector_t5: assert property (hardware_vector_call && vec_src_reg == 4'h0
        |-> vector_addr == `MCIS_VEC_T5)
        else $error("wrong vector address for timer five");

    cov_call: cover property (hardware_vector_call);
    cov_preempt: cover property (hardware_vector_call && $past(act_any));
    cov_interrupt_return_instruction_then_call: cover property (core_interrupt_return_instruction_done ##[1:40] hardware_vector_call);
    cov_ext4_call: cover property (hardware_vector_call && vector_addr == `MCIS_VEC_EXT4);
endmodule : mcis_sequencer
`default_nettype wire

// *** mcis_sequencer_tb_top.sv ***
// Self-checking bench of the interrupt sequencer with a behavioural core.
// Assumes the register map and vectors of mcis_regs.svh.
`timescale 1ns/1ps
`default_nettype none
`include "mcis_regs.svh"
module mcis_sequencer_tb_top;
    logic ref_clk, nrst, reg_wr, reg_rd, do_interrupt_return_instruction, sleep, x2, x3;
    logic lc, isr, rdn, slp, call, busy, wake, plc;
    logic [3:0] reg_addr, x4;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [9:0] pf;
    logic [4:0] ilen;
    logic [15:0] vaddr;
    logic [1:0] vlvl;
    logic [15:0] vt [11];
    int pb [11] = '{0, 1, 3, 4, 0, 0, 0, 5, 6, 7, 8};
    int n_fail, check_count, cyc, n, i;
    mcis_sequencer u_mcis_sequencer (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_five_overflow_flag(pf[0]), .serial_receive_flag(pf[1]),
        .serial_transmit_flag(pf[2]), .timer_two_overflow_flag(pf[3]),
        .converter_done_flag(pf[4]), .timer_three_overflow_flag(pf[5]),
        .pulse_width_flag(pf[6]), .timer_four_overflow_flag(pf[7]),
        .clock_monitor_flag(pf[8]), .low_voltage_detect_flag(pf[9]),
        .ext_irq_two_pin(x2), .ext_irq_three_pin(x3), .ext_irq_four_group(x4),
        .core_last_cycle(lc), .core_is_interrupt_return_instruction(isr), .core_interrupt_return_instruction_done(rdn),
        .core_sleeping(slp), .hardware_vector_call(call), .vector_addr(vaddr),
        .vector_level(vlvl), .call_busy(busy), .wake_req(wake));
    mcis_core_model u_mcis_core_model (
        .ref_clk(ref_clk), .nrst(nrst), .ilen(ilen), .do_interrupt_return_instruction(do_interrupt_return_instruction), .sleep(sleep),
        .call_busy(busy), .core_last_cycle(lc), .core_is_interrupt_return_instruction(isr),
        .core_interrupt_return_instruction_done(rdn), .core_sleeping(slp));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    task close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Counts edges until the call pulse; 99 means no call came.
    task wcall(input int lim);
        n = 0;
        #1;
        do begin
            plc = lc;
            @(posedge ref_clk);
            #1 n++;
        end while (!call && n < lim);
        if (!call) n = 99;
    endtask : wcall
    task ret();
        int k;
        @(posedge ref_clk);
        do_interrupt_return_instruction <= 1'b1;
        #1;
        for (k = 0; k < 40 && !isr; k++) #10;
        @(posedge ref_clk);
        do_interrupt_return_instruction <= 1'b0;
        #1;
        for (k = 0; k < 40 && !rdn; k++) #10;
    endtask : ret
    task en(input int i);
        wr(`MCIS_ADDR_EN_LO, i < 7 ? 8'h01 << i : 8'h00);
        wr(`MCIS_ADDR_EN_HI, i < 7 ? 8'h00 : (i == 10 ? 8'h18 : 8'h01 << (i - 7)));
    endtask : en
    task fire(input int i, input logic v);
        if (i > 3 && i < 7) wr(`MCIS_ADDR_EXT_FLAG, v ? 8'h01 << (i == 6 ? 2 : i - 4) : 8'h00);
        else begin
            @(posedge ref_clk);
            pf[pb[i]] <= v;
        end
    endtask : fire
    // One peripheral bit under given enables; a zero vector means no call is due.
    task one(input int b, input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
        wr(`MCIS_ADDR_EN_LO, lo);
        wr(`MCIS_ADDR_EN_HI, hi);
        @(posedge ref_clk);
        pf[b] <= 1'b1;
        wcall(30);
        if (v == 16'h0000) chk("no call", n, 99);
        else chk("vector", vaddr, v);
        @(posedge ref_clk);
        pf[b] <= 1'b0;
        if (v != 16'h0000) ret();
    endtask : one
    task s_vectors();
        wr(`MCIS_ADDR_TRIG, 8'h15);
        wr(`MCIS_ADDR_PIN4_EN, 8'h0f);
        for (i = 0; i < 11; i++) begin
            en(i);
            fire(i, 1'b1);
            wcall(30);
            chk("vector", vaddr, vt[i]);
            if (i == 0) chk("latency", n, 3);
            for (n = 0; busy && n < 20; n++) #10;
            if (i == 0) chk("busy cycles", n, 7);
            rd(`MCIS_ADDR_STATUS);
            chk("status", d, {i[3:0], 4'h1});
            rd(`MCIS_ADDR_EXT_FLAG);
            if (i == 4 || i == 6) chk("ext flag", d, i == 6 ? 8'h04 : 8'h00);
            fire(i, 1'b0);
            ret();
        end
        rd(`MCIS_ADDR_STATUS);
        chk("in progress", d[3:0], 4'h0);
        one(2, 8'h02, 8'h00, `MCIS_VEC_SERIAL);
        one(9, 8'h00, 8'h20, `MCIS_VEC_CM_LV);
        one(8, 8'h00, 8'h08, 16'h0000);
        one(0, 8'hfe, 8'h3f, 16'h0000);
        rd(4'hf);
        chk("unmapped", d, 8'h00);
    endtask : s_vectors
    task s_prio();
        // Enables stay off while the priority bytes change.
        wr(`MCIS_ADDR_EN_LO, 8'h00);
        wr(`MCIS_ADDR_EN_HI, 8'h00);
        wr(`MCIS_ADDR_PRI_LO1, 8'h02);
        wr(`MCIS_ADDR_PRI_HI1, 8'h02);
        wr(`MCIS_ADDR_EN_LO, 8'h05);
        wr(`MCIS_ADDR_EN_HI, 8'h04);
        @(posedge ref_clk);
        pf <= 10'h089;
        wcall(30);
        chk("top vector", vaddr, `MCIS_VEC_T4);
        chk("top level", vlvl, 2'h3);
        @(posedge ref_clk);
        pf[7] <= 1'b0;
        wcall(20);
        chk("blocked", n, 99);
        ret();
        wcall(30);
        chk("return wait", n >= 8 && n != 99, 1'b1);
        chk("order", vaddr, `MCIS_VEC_T5);
        @(posedge ref_clk);
        pf[7] <= 1'b1;
        wcall(30);
        chk("preempt", vaddr, `MCIS_VEC_T4);
        rd(`MCIS_ADDR_STATUS);
        chk("nested", d[3:0], 4'h9);
        @(posedge ref_clk);
        pf[7] <= 1'b0;
        ret();
        rd(`MCIS_ADDR_STATUS);
        chk("unwound", d[3:0], 4'h1);
        fire(0, 1'b0);
        ret();
        wcall(30);
        chk("next", vaddr, `MCIS_VEC_T2);
        fire(2, 1'b0);
        ret();
    endtask : s_prio
    task s_block();
        @(posedge ref_clk);
        ilen <= 5'h14;
        do @(posedge ref_clk); while (!lc);
        pf[0] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        pf[0] <= 1'b0;
        wcall(30);
        chk("dropped", n, 99);
        fire(0, 1'b1);
        wcall(40);
        chk("final cycle", plc, 1'b1);
        @(posedge ref_clk);
        pf[0] <= 1'b0;
        ilen <= 5'h01;
        ret();
    endtask : s_block
    task s_pins();
        wr(`MCIS_ADDR_EN_LO, 8'h00);
        wr(`MCIS_ADDR_TRIG, 8'h01);
        // Each pin level is held for several machine cycles.
        @(posedge ref_clk);
        x2 <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(`MCIS_ADDR_EXT_FLAG);
        chk("fall", d[0], 1'b1);
        wr(`MCIS_ADDR_TRIG, 8'h02);
        wr(`MCIS_ADDR_EXT_FLAG, 8'h00);
        @(posedge ref_clk);
        x2 <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rd(`MCIS_ADDR_EXT_FLAG);
        chk("rise", d[0], 1'b1);
        wr(`MCIS_ADDR_TRIG, 8'h00);
        rd(`MCIS_ADDR_EXT_FLAG);
        chk("level high", d[0], 1'b0);
        wr(`MCIS_ADDR_EN_LO, 8'h10);
        // The pin stays low through the first call and its return, until a second call is taken.
        @(posedge ref_clk);
        x2 <= 1'b0;
        wcall(30);
        chk("level call", vaddr, `MCIS_VEC_EXT2);
        ret();
        wcall(30);
        chk("still low", vaddr, `MCIS_VEC_EXT2);
        @(posedge ref_clk);
        x2 <= 1'b1;
        repeat (6) @(posedge ref_clk);
        ret();
        // Channel three on both edges, channel four on falling edges, sources left disabled.
        wr(`MCIS_ADDR_TRIG, 8'h1f);
        @(posedge ref_clk);
        x3 <= 1'b0;
        x4 <= 4'hd;
        repeat (6) @(posedge ref_clk);
        rd(`MCIS_ADDR_EXT_FLAG);
        chk("both edge and group pin", d, 8'h0a);
    endtask : s_pins
    task s_wake();
        en(0);
        @(posedge ref_clk);
        sleep <= 1'b1;
        pf[0] <= 1'b1;
        #1;
        for (n = 0; !wake && n < 10; n++) #10;
        chk("wake", wake, 1'b1);
        @(posedge ref_clk);
        sleep <= 1'b0;
        wcall(30);
        chk("after wake", vaddr, `MCIS_VEC_T5);
        fire(0, 1'b0);
        ret();
    endtask : s_wake
    initial begin
        nrst = 1'b0;
        {reg_wr, reg_rd, do_interrupt_return_instruction, sleep} = 4'h0;
        {x2, x3, x4} = 6'h3f;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        pf = 10'h000;
        ilen = 5'h01;
        vt = '{`MCIS_VEC_T5, `MCIS_VEC_SERIAL, `MCIS_VEC_T2, `MCIS_VEC_ADC, `MCIS_VEC_EXT2,
            `MCIS_VEC_EXT3, `MCIS_VEC_EXT4, `MCIS_VEC_T3, `MCIS_VEC_PWM, `MCIS_VEC_T4,
            `MCIS_VEC_CM_LV};
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        chk("reset vector", vaddr, 16'h0000);
        s_vectors();
        s_prio();
        s_block();
        s_pins();
        s_wake();
        close_out();
    end
endmodule : mcis_sequencer_tb_top
`default_nettype wire
